//--- bench/adc_ctrl_chk.sv
`timescale 1ns/10ps
module adc_ctrl_chk
   import adc_fifo_ctrl_pkg::*;
(
   // Watched ports
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        ce_in,
   input wire logic [7:0]  addr_in,
   input wire word_type    wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire word_type    rdata_out,
   input wire logic        single_full_out,
   input wire logic        scan_full_out,
   input wire inhibit_type positive_input_select_in,
   input wire inhibit_type negative_input_select_in,
   input wire inhibit_type scan_input_select_in,
   input wire inhibit_type bus_request_out,
   input wire inhibit_type channel_select_active_out,
   input wire inhibit_type request_inhibit_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Decoded accesses
   inhibit_type wr_bits;
   logic        inh_wr;
   inhibit_type any_sel;
   assign wr_bits = wdata_in[9:2];
   assign inh_wr = ce_in && wr_in && addr_in == 8'h94;
   assign any_sel = positive_input_select_in | negative_input_select_in | scan_input_select_in;
   sequence s_wr(a);
      ce_in && wr_in && addr_in == a;
   endsequence
   sequence s_rd(a);
      ce_in && rd_in && addr_in == a;
   endsequence
   a_req_mask: assert property (bus_request_out == (any_sel & ~request_inhibit_out))
      else $error("bus request mismatch");
   a_passive_sel: assert property (channel_select_active_out == bus_request_out)
      else $error("own selection on passive bus");
   a_inhibit_load: assert property (inh_wr |=> request_inhibit_out == $past(wr_bits))
      else $error("inhibit write lost");
   a_inhibit_hold: assert property (!inh_wr |=> $stable(request_inhibit_out))
      else $error("inhibit changed unasked");
   a_single_flush: assert property (s_wr(8'h8C) ##0 wdata_in[0] |=> !single_full_out)
      else $error("single flush failed");
   a_scan_flush: assert property (s_wr(8'h90) ##0 wdata_in[0] |=> !scan_full_out)
      else $error("scan flush failed");
   a_inhibit_read: assert property (s_rd(8'h94) |=>
      rdata_out == {22'h0, $past(request_inhibit_out), 2'h0})
      else $error("inhibit read wrong");
   a_rdata_idle: assert property (ce_in && !rd_in |=> rdata_out == 32'h0)
      else $error("read data not idle");
endmodule
bind adc_fifo_count_and_bus_master_ctrl adc_ctrl_chk adc_ctrl_chk_inst (.clk_in, .rst_n_in,
   .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .single_full_out, .scan_full_out,
   .positive_input_select_in, .negative_input_select_in, .scan_input_select_in,
   .bus_request_out, .channel_select_active_out, .request_inhibit_out);

//--- bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import adc_fifo_ctrl_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in, ce_in, wr_in, rd_in, single_push_in, scan_push_in;
   logic single_full_out, scan_full_out;
   logic [7:0] addr_in;
   word_type wdata_in, rdata_out, single_result_in, scan_result_in, rv;
   inhibit_type positive_input_select_in, negative_input_select_in, scan_input_select_in;
   inhibit_type bus_request_out, channel_select_active_out, request_inhibit_out;
   int bad_count = 0;
   int check_count = 0;
   // Clock
   always #20 clk_in = ~clk_in;
   adc_fifo_count_and_bus_master_ctrl adc_fifo_count_and_bus_master_ctrl_inst (.clk_in,
      .rst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .single_push_in,
      .single_result_in, .scan_push_in, .scan_result_in, .single_full_out, .scan_full_out,
      .positive_input_select_in, .negative_input_select_in, .scan_input_select_in,
      .bus_request_out, .channel_select_active_out, .request_inhibit_out);
   // Compare and bus tasks
   task automatic chk(input word_type exp, input word_type got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input word_type d);
      @(posedge clk_in); addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge clk_in); wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in); addr_in <= a; rd_in <= 1'b1;
      @(posedge clk_in); rd_in <= 1'b0;
      #1 rv = rdata_out;
   endtask
   task automatic push(input bit scan, input word_type d);
      @(posedge clk_in);
      if (scan) begin
         scan_push_in <= 1'b1; scan_result_in <= d;
      end else begin
         single_push_in <= 1'b1; single_result_in <= d;
      end
      @(posedge clk_in); single_push_in <= 1'b0; scan_push_in <= 1'b0;
   endtask
   // Fill, peek, pop, flush one result store
   task automatic test_fifo(input bit scan);
      logic [7:0] cnt, pop;
      cnt = scan ? 8'h88 : 8'h84;
      pop = scan ? 8'hA8 : 8'hA0;
      for (int i = 0; i < 5; i++) push(scan, 32'hC0DE0000 + i);
      rd(cnt); chk(32'h4, rv);
      chk(32'h1, {31'h0, scan ? scan_full_out : single_full_out});
      rd(pop + 8'h4); chk(32'hC0DE0000, rv);
      rd(cnt); chk(32'h4, rv);
      rd(pop); chk(32'hC0DE0000, rv);
      rd(pop); chk(32'hC0DE0001, rv);
      rd(cnt); chk(32'h2, rv);
      wr(cnt + 8'h8, 32'h0); rd(cnt); chk(32'h2, rv);
      wr(cnt + 8'h8, 32'h1); rd(cnt); chk(32'h0, rv);
      push(scan, 32'h5); rd(cnt); chk(32'h1, rv);
      wr(cnt + 8'h8, 32'h1);
      $display("test fifo %0d done", scan);
   endtask
   // Reset values and an unmapped read
   task automatic test_reset;
      rd(8'h84); chk(32'h0, rv);
      rd(8'h88); chk(32'h0, rv);
      rd(8'h94); chk(32'h0, rv);
      rd(8'h00); chk(32'h0, rv);
      $display("test reset done");
   endtask
   // Request masking for several inhibit patterns
   task automatic test_inhibit;
      inhibit_type pat[4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
      // Bench stands in for the outside master choosing channels
      @(posedge clk_in); positive_input_select_in <= 8'h0F;
      negative_input_select_in <= 8'h30; scan_input_select_in <= 8'hC0;
      @(posedge clk_in); #1 chk(32'hFF, {24'h0, bus_request_out});
      foreach (pat[i]) begin
         wr(8'h94, {22'h0, pat[i], 2'h0});
         rd(8'h94);
         chk({22'h0, pat[i], 2'h0}, rv);
         chk({24'h0, ~pat[i]}, {24'h0, bus_request_out});
         chk({24'h0, ~pat[i]}, {24'h0, channel_select_active_out});
      end
      $display("test inhibit done");
   endtask
   // Back-to-back popping reads with no gap between strobes
   task automatic test_burst;
      push(1'b0, 32'hBEEF0001);
      push(1'b0, 32'hBEEF0002);
      @(posedge clk_in);
      addr_in <= 8'hA0;
      rd_in <= 1'b1;
      @(posedge clk_in);
      #1 chk(32'hBEEF0001, rdata_out);
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(32'hBEEF0002, rdata_out);
      rd(8'h84); chk(32'h0, rv);
      $display("test burst done");
   endtask
   // Enable low freezes state; a mid-run reset clears the inhibit bits
   task automatic test_enable;
      wr(8'h94, 32'h0000_0154);
      @(posedge clk_in);
      ce_in <= 1'b0;
      wr(8'h94, 32'h0000_03FC);
      push(1'b1, 32'h0000_0007);
      @(posedge clk_in);
      ce_in <= 1'b1;
      rd(8'h94); chk(32'h154, rv);
      rd(8'h88); chk(32'h0, rv);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(8'h94); chk(32'h0, rv);
      chk(32'hFF, {24'h0, bus_request_out});
      $display("test enable done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence and watchdog
   initial begin
      {rst_n_in, wr_in, rd_in, single_push_in, scan_push_in} = '0;
      {addr_in, wdata_in, single_result_in, scan_result_in} = '0;
      {positive_input_select_in, negative_input_select_in, scan_input_select_in} = '0;
      ce_in = 1'b1;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      test_reset;
      test_fifo(1'b0);
      test_fifo(1'b1);
      test_burst;
      test_inhibit;
      test_enable;
      conclude;
   end
   initial begin
      #100000;
      bad_count++;
      conclude;
   end
endmodule

//--- rtl/adc_fifo_count_and_bus_master_ctrl.sv
`timescale 1ns/10ps
`include "adc_fifo_ctrl_regs.svh"
//------------------------------------------------------------
// Behaviour
// - Single FIFO unread count reads at bits 2:0 of offset 0x084.
// - Scan FIFO unread count reads at bits 2:0 of offset 0x088.
// - Writing one to bit 0 at 0x08C empties the single FIFO; zero does nothing.
// - Writing one to bit 0 at 0x090 empties the scan FIFO; zero does nothing.
// - With an inhibit bit clear, a bus chosen by any input selector is requested.
// - With an inhibit bit set, that bus is not requested and own selection ignored.
// - Inhibit lets several peripherals watch one bus while only the master selects.
// - Reading a popping data register removes one entry, lowering its count.
// - Reading a peek register returns the oldest entry without removing it.
//------------------------------------------------------------
module adc_fifo_count_and_bus_master_ctrl
   import adc_fifo_ctrl_pkg::*;
(
   // Clock, enable, reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire word_type    wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output word_type         rdata_out,
   // Conversion results
   input  wire logic        single_push_in,
   input  wire word_type    single_result_in,
   input  wire logic        scan_push_in,
   input  wire word_type    scan_result_in,
   output logic             single_full_out,
   output logic             scan_full_out,
   // Bus selection, one bit per bus half, bit 0 = bus1 x
   input  wire inhibit_type positive_input_select_in,
   input  wire inhibit_type negative_input_select_in,
   input  wire inhibit_type scan_input_select_in,
   output inhibit_type      bus_request_out,
   output inhibit_type      channel_select_active_out,
   output inhibit_type      request_inhibit_out
);
   //------------------------------------------------------------
   // Internal signals
   //------------------------------------------------------------
   // Inhibit register and its named fields
   inhibit_type inhibit_ff;
   logic        bus1_x_request_inhibit;
   logic        bus1_y_request_inhibit;
   logic        bus2_x_request_inhibit;
   logic        bus2_y_request_inhibit;
   logic        bus3_x_request_inhibit;
   logic        bus3_y_request_inhibit;
   logic        bus4_x_request_inhibit;
   logic        bus4_y_request_inhibit;
   inhibit_type inhibit_fields;

   // Result store status
   count_type   single_count;
   count_type   scan_count;
   word_type    single_head;
   word_type    scan_head;

   // Decoded accesses
   logic        single_flush;
   logic        scan_flush;
   logic        single_pop;
   logic        scan_pop;
   logic        inhibit_wr;

   // Request path and read path
   inhibit_type chosen;
   word_type    nxt_rdata;
   word_type    rdata_ff;

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Address match against one register offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Unread count placed in bits 2:0, reserved bits zero
   function automatic word_type count_word(input count_type cnt);
      count_word = {29'h0, cnt};
   endfunction

   // Inhibit bits placed in bits 9:2, reserved bits zero
   function automatic word_type inhibit_word(input inhibit_type inh);
      inhibit_word = {22'h0, inh, 2'h0};
   endfunction

   // Bus halves chosen and not inhibited
   // Shared by the request and the selection outputs
   function automatic inhibit_type mastered(input inhibit_type sel, input inhibit_type inh);
      mastered = sel & ~inh;
   endfunction

   //------------------------------------------------------------
   // Access decode
   //------------------------------------------------------------
   // Flush strobes on a write of one; a write of zero does nothing
   assign single_flush = wr_in && hit(addr_in, `OFS_SINGLE_FLUSH)
                         && wdata_in[`FLUSH_BIT];
   assign scan_flush   = wr_in && hit(addr_in, `OFS_SCAN_FLUSH)
                         && wdata_in[`FLUSH_BIT];
   // Popping reads only; peeks leave the store alone
   assign single_pop   = rd_in && hit(addr_in, `OFS_SINGLE_DATA_POP);
   assign scan_pop     = rd_in && hit(addr_in, `OFS_SCAN_DATA_POP);
   // Inhibit write; read-only and unmapped writes decode to nothing
   assign inhibit_wr   = wr_in && hit(addr_in, `OFS_REQUEST_INHIBIT);

   //------------------------------------------------------------
   // Result stores
   //------------------------------------------------------------
   // Single-conversion store
   result_fifo u_single (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ce_in        (ce_in),
      .push_in      (single_push_in),
      .push_data_in (single_result_in),
      .pop_in       (single_pop),
      .flush_in     (single_flush),
      .full_out     (single_full_out),
      .count_out    (single_count),
      .head_out     (single_head)
   );

   // Scan-conversion store
   result_fifo u_scan (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .ce_in        (ce_in),
      .push_in      (scan_push_in),
      .push_data_in (scan_result_in),
      .pop_in       (scan_pop),
      .flush_in     (scan_flush),
      .full_out     (scan_full_out),
      .count_out    (scan_count),
      .head_out     (scan_head)
   );

   //------------------------------------------------------------
   // Inhibit register
   //------------------------------------------------------------
   // Eight read-write bits, cleared by reset; bits 1:0 and 31:10 not stored
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         inhibit_ff <= `RST_INHIBIT;
      end else if (ce_in && inhibit_wr) begin
         inhibit_ff <= wdata_in[`INHIBIT_MSB:`INHIBIT_LSB];
      end
   end

   //------------------------------------------------------------
   // Inhibit fields
   //------------------------------------------------------------
   // One field per bus half, bit 0 is bus1 x
   assign bus1_x_request_inhibit = inhibit_ff[0];
   assign bus1_y_request_inhibit = inhibit_ff[1];
   assign bus2_x_request_inhibit = inhibit_ff[2];
   assign bus2_y_request_inhibit = inhibit_ff[3];
   assign bus3_x_request_inhibit = inhibit_ff[4];
   assign bus3_y_request_inhibit = inhibit_ff[5];
   assign bus4_x_request_inhibit = inhibit_ff[6];
   assign bus4_y_request_inhibit = inhibit_ff[7];
   // Fields back in bus order for the request mask
   assign inhibit_fields = {bus4_y_request_inhibit, bus4_x_request_inhibit,
                            bus3_y_request_inhibit, bus3_x_request_inhibit,
                            bus2_y_request_inhibit, bus2_x_request_inhibit,
                            bus1_y_request_inhibit, bus1_x_request_inhibit};

   //------------------------------------------------------------
   // Bus request
   //------------------------------------------------------------
   // Any of the three selectors may choose a bus half
   assign chosen = positive_input_select_in | negative_input_select_in
                   | scan_input_select_in;
   // Request only buses whose inhibit bit is clear
   assign bus_request_out           = mastered(chosen, inhibit_fields);
   // Own channel selection drives only buses we master
   assign channel_select_active_out = mastered(chosen, inhibit_fields);
   // Inhibit state shown to the other peripherals on the bus
   assign request_inhibit_out       = inhibit_ff;

   //------------------------------------------------------------
   // Read data, one cycle after strobe
   //------------------------------------------------------------
   // Next read word; idle and unmapped reads give zero
   always_comb begin
      nxt_rdata = `RST_WORD;
      if (rd_in) begin
         case (addr_in)
            `OFS_SINGLE_FILL_COUNT: nxt_rdata = count_word(single_count);
            `OFS_SCAN_FILL_COUNT:   nxt_rdata = count_word(scan_count);
            `OFS_REQUEST_INHIBIT:   nxt_rdata = inhibit_word(inhibit_ff);
            // Data reads: pop and peek return the same oldest entry
            `OFS_SINGLE_DATA_POP,
            `OFS_SINGLE_DATA_PEEK:  nxt_rdata = single_head;
            `OFS_SCAN_DATA_POP,
            `OFS_SCAN_DATA_PEEK:    nxt_rdata = scan_head;
            default:                nxt_rdata = `RST_WORD;
         endcase
      end
   end

   // Read word register, frozen while the enable is low
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_ff <= `RST_WORD;
      end else if (ce_in) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Registered read word to the port
   assign rdata_out = rdata_ff;
endmodule

//--- rtl/result_fifo.sv
`timescale 1ns/10ps
`include "adc_fifo_ctrl_regs.svh"
// Four-entry result store with registered head output
module result_fifo
   import adc_fifo_ctrl_pkg::*;
(
   // Clock, enable and reset
   input  wire logic      clk_in,
   input  wire logic      rst_n_in,
   input  wire logic      ce_in,
   // Control
   input  wire logic      push_in,
   input  wire word_type  push_data_in,
   input  wire logic      pop_in,
   input  wire logic      flush_in,
   // Status
   output logic           full_out,
   output count_type      count_out,
   output word_type       head_out
);
   word_type   mem_ff [4];
   logic [1:0] wr_ptr_ff;
   logic [1:0] rd_ptr_ff;
   count_type  count_ff;
   logic       do_push;
   logic       do_pop;
   logic [1:0] nxt_rd_ptr;

   assign full_out  = (count_ff == `FIFO_DEPTH);
   assign count_out = count_ff;
   assign do_push   = push_in && !full_out;
   assign do_pop    = pop_in && (count_ff != 3'h0);
   // Read pointer after this edge, so the head keeps up with back-to-back pops
   assign nxt_rd_ptr = flush_in ? 2'h0 : (rd_ptr_ff + {1'b0, do_pop});

   // Storage write
   always_ff @(posedge clk_in) begin
      if (ce_in && do_push && !flush_in) begin
         mem_ff[wr_ptr_ff] <= push_data_in;
      end
   end

   // Pointers and count; flush empties
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_ff <= 2'h0;
         rd_ptr_ff <= 2'h0;
         count_ff  <= `RST_COUNT;
      end else if (ce_in) begin
         if (flush_in) begin
            wr_ptr_ff <= 2'h0;
            rd_ptr_ff <= 2'h0;
            count_ff  <= 3'h0;
         end else begin
            if (do_push) begin
               wr_ptr_ff <= wr_ptr_ff + 2'h1;
            end
            if (do_pop) begin
               rd_ptr_ff <= rd_ptr_ff + 2'h1;
            end
            count_ff <= count_ff + {2'h0, do_push} - {2'h0, do_pop};
         end
      end
   end

   // Registered oldest entry as it stands after this edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         head_out <= `RST_WORD;
      end else if (ce_in) begin
         if (do_push && !flush_in && (wr_ptr_ff == nxt_rd_ptr)) begin
            head_out <= push_data_in; // Pushed word becomes the head
         end else begin
            head_out <= mem_ff[nxt_rd_ptr];
         end
      end
   end
endmodule

//--- shared/adc_fifo_ctrl_pkg.sv
package adc_fifo_ctrl_pkg;
   typedef logic [2:0]  count_type;
   typedef logic [31:0] word_type;
   typedef logic [7:0]  inhibit_type;
endpackage

//--- shared/adc_fifo_ctrl_regs.svh
`ifndef ADC_FIFO_CTRL_REGS_SVH
`define ADC_FIFO_CTRL_REGS_SVH

// Register byte offsets
`define OFS_SINGLE_FILL_COUNT  8'h84
`define OFS_SCAN_FILL_COUNT    8'h88
`define OFS_SINGLE_FLUSH       8'h8C
`define OFS_SCAN_FLUSH         8'h90
`define OFS_REQUEST_INHIBIT    8'h94
`define OFS_SINGLE_DATA_POP    8'hA0
`define OFS_SINGLE_DATA_PEEK   8'hA4
`define OFS_SCAN_DATA_POP      8'hA8
`define OFS_SCAN_DATA_PEEK     8'hAC

// Field positions
`define COUNT_MSB              2
`define FLUSH_BIT              0
`define INHIBIT_LSB            2
`define INHIBIT_MSB            9

// Reset values
`define RST_INHIBIT            8'h00
`define RST_COUNT              3'h0
`define RST_WORD               32'h0000_0000

// Store depth
`define FIFO_DEPTH             3'h4

`endif
